// *** hdl/fcpwm_top.sv ***
// Four-channel PWM controller: clock generator, channels and control ports.
//
// Summary of operation
// - One clock generator, four independent channels.
// - Eleven prescaled ticks, divides one to 1024.
// - Two linear dividers, factor 1..255.
// - Divider factors and selects reset to zero.
// - Prescaler stopped at reset and clock gating.
// - Sixteen-bit counter ticks on selected clock.
// - Channel clock select resets to zero.
// - Left aligned counts up, resets at period.
// - Center aligned counts up then down.
// - Polarity picks level at period start.
// - Alignment selects left or center mode.
// - Fixed low at duty=period pol0, duty0 pol1.
// - Fixed high at duty=period with pol1.
// - Polarity changes only while channel disabled.
// - Direct period/duty writes only when disabled.
// - Update value held until period end.
// - Update target bit picks period or duty.
// - One enable write starts channels together.
// - Masked period end raises interrupt until read.
// - Status read returns and clears flags.
// - Enable write of one enables channel.
// - Disable write of one disables; status shows.
// - Factor 0 stops, 1 passes, else divides.
`timescale 1ns/1ps
`default_nettype none
module fcpwm_top
    import fcpwm_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CLK_GATE,
    input wire fcpwm_gen_s GEN_CFG,
    input wire fcpwm_mode_s [FCPWM_NCH-1:0] MODE_CFG,
    input wire logic [FCPWM_NCH-1:0] MODE_WR,
    input wire logic [FCPWM_NCH-1:0] PERIOD_WR,
    input wire logic [FCPWM_NCH-1:0] DUTY_WR,
    input wire logic [FCPWM_NCH-1:0] UPDATE_WR,
    input wire logic [FCPWM_CNT_W-1:0] WR_DATA,
    input wire logic [FCPWM_NCH-1:0] ENABLE_WR,
    input wire logic [FCPWM_NCH-1:0] DISABLE_WR,
    input wire logic [FCPWM_NCH-1:0] IRQ_ENABLE_WR,
    input wire logic [FCPWM_NCH-1:0] IRQ_DISABLE_WR,
    input wire logic IRQ_FLAGS_RD,
    output logic [FCPWM_NCH-1:0] CHANNEL_WAVE_OUT,
    output logic [FCPWM_NCH-1:0] CHANNEL_STATUS,
    output logic [FCPWM_NCH-1:0] IRQ_MASK,
    output logic [FCPWM_NCH-1:0] IRQ_FLAGS,
    output logic IRQ,
    output logic [FCPWM_NCH*FCPWM_CNT_W-1:0] COUNTER_VALUE
);
    // ========================================
    // Clock generator
    logic [9:0] pre_cnt, next_pre_cnt;
    logic [FCPWM_NPRE-1:0] pre_tick;
    fcpwm_gen_s gen, next_gen;
    logic [7:0] div_a_cnt, next_div_a_cnt, div_b_cnt, next_div_b_cnt;
    logic tick_a, tick_b;
    logic [12:0] gen_tick;

    // Prescaled ticks: bit k fires once every 2**k master clocks.
    always_comb begin
        // gated master clock freezes the prescaler, only the undivided tick runs
        next_pre_cnt = CLK_GATE ? pre_cnt : pre_cnt + 10'h_0001;
        pre_tick[0] = 1'b1;
        for (int k = 1; k < FCPWM_NPRE; k++) begin
            // divide by two to the k
            pre_tick[k] = !CLK_GATE && ((pre_cnt & ((10'h_0001 << k) - 10'h_0001)) == 10'h_0000);
        end
    end

    // Generator settings and the two linear dividers.
    always_comb begin
        next_gen = GEN_CFG;
        next_div_a_cnt = div_a_cnt;
        next_div_b_cnt = div_b_cnt;
        tick_a = 1'b0;
        tick_b = 1'b0;
        // count source ticks, pulse when factor reached; factor 0 keeps it quiet
        if (gen.divider_a_factor != 8'h_0000 && gen.prescale_a_select < 4'(FCPWM_NPRE)
                && pre_tick[gen.prescale_a_select]) begin
            if (div_a_cnt + 8'h_0001 >= gen.divider_a_factor) begin
                next_div_a_cnt = 8'h_0000;
                tick_a = 1'b1;
            end else begin
                next_div_a_cnt = div_a_cnt + 8'h_0001;
            end
        end
        if (gen.divider_b_factor != 8'h_0000 && gen.prescale_b_select < 4'(FCPWM_NPRE)
                && pre_tick[gen.prescale_b_select]) begin
            if (div_b_cnt + 8'h_0001 >= gen.divider_b_factor) begin
                next_div_b_cnt = 8'h_0000;
                tick_b = 1'b1;
            end else begin
                next_div_b_cnt = div_b_cnt + 8'h_0001;
            end
        end
        gen_tick = {tick_b, tick_a, pre_tick};
    end

    // divider fields clear at reset, so both divided clocks start stopped.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pre_cnt <= FCPWM_PRE_RST_CNT;
            gen <= '{FCPWM_PRE_RST, FCPWM_DIV_RST, FCPWM_PRE_RST, FCPWM_DIV_RST};
            div_a_cnt <= FCPWM_DIV_RST;
            div_b_cnt <= FCPWM_DIV_RST;
        end else begin
            pre_cnt <= next_pre_cnt;
            gen <= next_gen;
            div_a_cnt <= next_div_a_cnt;
            div_b_cnt <= next_div_b_cnt;
        end
    end

    // ========================================
    // Control, interrupt mask and flags
    logic [FCPWM_NCH-1:0] ena, next_ena, mask, next_mask, flags, next_flags, period_end;

    always_comb begin
        // all bits of one enable write act in the same cycle
        next_ena = (ena | ENABLE_WR) & ~DISABLE_WR;
        // mask set and cleared by write-one strobes
        next_mask = (mask | IRQ_ENABLE_WR) & ~IRQ_DISABLE_WR;
        // read clears, a period end in the same cycle wins
        next_flags = (IRQ_FLAGS_RD ? '0 : flags) | period_end;
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ena <= '0;
            mask <= '0;
            flags <= '0;
        end else begin
            ena <= next_ena;
            mask <= next_mask;
            flags <= next_flags;
        end
    end

    assign CHANNEL_STATUS = ena;
    assign IRQ_MASK = mask;
    assign IRQ_FLAGS = flags;
    // line stays high while any unmasked flag is pending.
    assign IRQ = |(flags & mask);

    // ========================================
    // Channels
    // one identical channel per output line
    for (genvar c = 0; c < FCPWM_NCH; c++) begin : g_chan
        fcpwm_mode_s mode, next_mode;
        logic [15:0] prd, next_prd, dty, next_dty, upd, next_upd, cnt, next_cnt;
        logic upd_pend, next_upd_pend, wave, next_wave, tick, pend_c;
        fcpwm_dir_e dir, next_dir;

        always_comb begin
            next_mode = mode;
            next_prd = prd;
            next_dty = dty;
            next_upd = upd;
            next_upd_pend = upd_pend;
            next_cnt = cnt;
            next_dir = dir;
            pend_c = 1'b0;
            // advance only on the selected generator tick
            tick = (mode.chan_clock_select <= FCPWM_SEL_DIVIDER_B_FACTOR) && gen_tick[mode.chan_clock_select];
            // mode writes taken only while disabled
            if (MODE_WR[c] && !ena[c]) begin
                next_mode = MODE_CFG[c];
            end
            if (!ena[c] && PERIOD_WR[c]) begin
                next_prd = WR_DATA;
            end
            if (!ena[c] && DUTY_WR[c]) begin
                next_dty = WR_DATA;
            end
            // hold the update value until the period ends
            if (UPDATE_WR[c]) begin
                next_upd = WR_DATA;
                next_upd_pend = 1'b1;
            end
            if (!ena[c]) begin
                next_cnt = FCPWM_VAL_RST;
                next_dir = FCPWM_UP;
            end else if (tick) begin
                unique case (dir)
                    FCPWM_UP: begin
                        if (cnt >= prd) begin
                            if (mode.center_align_sel) begin
                                // turn round at the period value
                                next_dir = FCPWM_DOWN;
                                next_cnt = (cnt == 16'h_0000) ? cnt : cnt - 16'h_0001;
                                pend_c = (cnt == 16'h_0000);
                            end else begin
                                next_cnt = FCPWM_VAL_RST;
                                pend_c = 1'b1;
                            end
                        end else begin
                            next_cnt = cnt + 16'h_0001;
                        end
                    end
                    FCPWM_DOWN: begin
                        if (cnt <= 16'h_0001) begin
                            next_cnt = FCPWM_VAL_RST;
                            next_dir = FCPWM_UP;
                            pend_c = 1'b1;
                        end else begin
                            next_cnt = cnt - 16'h_0001;
                        end
                    end
                endcase
            end
            // transfer into period or duty at period end
            if (pend_c && upd_pend && !UPDATE_WR[c]) begin
                next_upd_pend = 1'b0;
                if (mode.update_target_sel) begin
                    next_prd = upd;
                end else begin
                    next_dty = upd;
                end
            end
            // start level below duty, opposite afterwards
            // duty equal to period never leaves start level; duty 0 never shows it
            if (!ena[c]) begin
                // disabled output follows polarity at once.
                next_wave = next_mode.start_polarity;
            end else begin
                next_wave = (next_cnt < next_dty) ? next_mode.start_polarity
                                                   : !next_mode.start_polarity;
                if (next_dty == next_prd) begin
                    next_wave = next_mode.start_polarity;
                end
            end
        end

        always_ff @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
                mode <= '{FCPWM_CSEL_RST, 1'b0, 1'b0, 1'b0};
                prd <= FCPWM_VAL_RST;
                dty <= FCPWM_VAL_RST;
                upd <= FCPWM_VAL_RST;
                upd_pend <= 1'b0;
                cnt <= FCPWM_VAL_RST;
                dir <= FCPWM_UP;
                wave <= 1'b0;
            end else begin
                mode <= next_mode;
                prd <= next_prd;
                dty <= next_dty;
                upd <= next_upd;
                upd_pend <= next_upd_pend;
                cnt <= next_cnt;
                dir <= next_dir;
                wave <= next_wave;
            end
        end

        assign period_end[c] = pend_c;
        assign CHANNEL_WAVE_OUT[c] = wave;
        assign COUNTER_VALUE[c*FCPWM_CNT_W +: FCPWM_CNT_W] = cnt;
    end
endmodule : fcpwm_top
`default_nettype wire

// *** hdl/fcpwm_pkg.sv ***
// Shared constants and carrier types for the four-channel PWM controller.
package fcpwm_pkg;
    // ========================================
    // Geometry and field positions
    localparam int FCPWM_NCH = 4;
    localparam int FCPWM_CNT_W = 16;
    localparam int FCPWM_NPRE = 11;
    localparam logic [3:0] FCPWM_SEL_DIVIDER_A_FACTOR = 4'h_000B;
    localparam logic [3:0] FCPWM_SEL_DIVIDER_B_FACTOR = 4'h_000C;
    // ========================================
    // Reset values
    localparam logic [7:0] FCPWM_DIV_RST = 8'h_0000;
    localparam logic [3:0] FCPWM_PRE_RST = 4'h_0000;
    localparam logic [3:0] FCPWM_CSEL_RST = 4'h_0000;
    localparam logic [15:0] FCPWM_VAL_RST = 16'h_0000;
    localparam logic [9:0] FCPWM_PRE_RST_CNT = 10'h_0000;

    // Per-channel mode settings.
    typedef struct packed {
        logic [3:0] chan_clock_select;
        logic center_align_sel;
        logic start_polarity;
        logic update_target_sel;
    } fcpwm_mode_s;

    // Clock generator settings.
    typedef struct packed {
        logic [3:0] prescale_b_select;
        logic [7:0] divider_b_factor;
        logic [3:0] prescale_a_select;
        logic [7:0] divider_a_factor;
    } fcpwm_gen_s;

    // Counter direction states.
    typedef enum logic [1:0] {
        FCPWM_UP = 2'b01,
        FCPWM_DOWN = 2'b10
    } fcpwm_dir_e;
endpackage : fcpwm_pkg

// *** bench/fcpwm_top_asserts.sv ***
// Port-level checker for the four-channel PWM controller.
`timescale 1ns/1ps
`default_nettype none
module fcpwm_asserts
    import fcpwm_pkg::*;
(
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [FCPWM_NCH-1:0] ENABLE_WR,
    input wire logic [FCPWM_NCH-1:0] DISABLE_WR,
    input wire logic [FCPWM_NCH-1:0] IRQ_ENABLE_WR,
    input wire logic [FCPWM_NCH-1:0] IRQ_DISABLE_WR,
    input wire logic IRQ_FLAGS_RD,
    input wire logic [FCPWM_NCH-1:0] CHANNEL_STATUS,
    input wire logic [FCPWM_NCH-1:0] IRQ_MASK,
    input wire logic [FCPWM_NCH-1:0] IRQ_FLAGS,
    input wire logic IRQ,
    input wire logic [FCPWM_NCH*FCPWM_CNT_W-1:0] COUNTER_VALUE
);
    // ========================================
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    AST_ENA_SETS: assert property ((ENABLE_WR & ~DISABLE_WR) != 4'h_0 |=>
        (CHANNEL_STATUS & $past(ENABLE_WR & ~DISABLE_WR)) == $past(ENABLE_WR & ~DISABLE_WR))
        else $error("enable strobe did not set status");
    AST_DIS_CLEARS: assert property (DISABLE_WR != 4'h_0 |=>
        (CHANNEL_STATUS & $past(DISABLE_WR)) == 4'h_0) else $error("disable strobe ignored");
    AST_IRQ_LEVEL: assert property (IRQ == |(IRQ_FLAGS & IRQ_MASK))
        else $error("interrupt line disagrees with flags and mask");
    AST_MASK_SET: assert property ((IRQ_ENABLE_WR & ~IRQ_DISABLE_WR) != 4'h_0 |=>
        (IRQ_MASK & $past(IRQ_ENABLE_WR)) == $past(IRQ_ENABLE_WR & ~IRQ_DISABLE_WR))
        else $error("mask not set");
    AST_MASK_CLR: assert property (IRQ_DISABLE_WR != 4'h_0 |=>
        (IRQ_MASK & $past(IRQ_DISABLE_WR)) == 4'h_0) else $error("mask not cleared");
    AST_FLAG_HOLD: assert property (!IRQ_FLAGS_RD |=>
        (IRQ_FLAGS & $past(IRQ_FLAGS)) == $past(IRQ_FLAGS)) else $error("flag lost unread");
    AST_FLAG_CLEAR: assert property (IRQ_FLAGS_RD && CHANNEL_STATUS == 4'h_0 |=>
        IRQ_FLAGS == 4'h_0) else $error("flag read did not clear flags");
    AST_FLAG_RUN: assert property ($rose(IRQ_FLAGS[0]) |-> $past(CHANNEL_STATUS[0]))
        else $error("period end flagged on an idle channel");
    AST_IDLE_COUNT: assert property (!CHANNEL_STATUS[0] && $past(!CHANNEL_STATUS[0]) |->
        COUNTER_VALUE[15:0] == 16'h_0000) else $error("idle counter not zero");
    AST_COUNT_STEP: assert property ($changed(COUNTER_VALUE[15:0]) |->
        COUNTER_VALUE[15:0] == $past(COUNTER_VALUE[15:0]) + 16'h_0001 ||
        COUNTER_VALUE[15:0] == $past(COUNTER_VALUE[15:0]) - 16'h_0001 ||
        COUNTER_VALUE[15:0] == 16'h_0000) else $error("counter jumped");
endmodule : fcpwm_asserts
bind fcpwm_top fcpwm_asserts fcpwm_asserts_inst (.CLK(CLK), .NRST(NRST),
    .ENABLE_WR(ENABLE_WR), .DISABLE_WR(DISABLE_WR), .IRQ_ENABLE_WR(IRQ_ENABLE_WR),
    .IRQ_DISABLE_WR(IRQ_DISABLE_WR), .IRQ_FLAGS_RD(IRQ_FLAGS_RD), .IRQ(IRQ),
    .CHANNEL_STATUS(CHANNEL_STATUS), .IRQ_MASK(IRQ_MASK), .IRQ_FLAGS(IRQ_FLAGS),
    .COUNTER_VALUE(COUNTER_VALUE));
`default_nettype wire

// *** bench/fcpwm_load.sv ***
// Load model on the waveform lines: counts the cycles each line is high.
`timescale 1ns/1ps
`default_nettype none
module fcpwm_load
    import fcpwm_pkg::*;
(
    input wire logic clk,
    input wire logic restart,
    input wire logic [FCPWM_NCH-1:0] wave,
    output logic [FCPWM_NCH-1:0][15:0] high_cnt
);
    // Restart counts the current cycle too, so no cycle of a window is lost.
    always_ff @(posedge clk) begin
        for (int c = 0; c < FCPWM_NCH; c++) begin
            high_cnt[c] <= (restart ? 16'h_0000 : high_cnt[c]) + 16'(wave[c]);
        end
    end
endmodule : fcpwm_load
`default_nettype wire

// *** bench/fcpwm_top_tb.sv ***
// Self-checking testbench for the four-channel PWM controller.
`timescale 1ns/1ps
`default_nettype none
module fcpwm_top_tb
    import fcpwm_pkg::*;
;
    typedef struct {string name; logic [15:0] exp; logic [15:0] got;} fcpwm_note_s;
    localparam int gap_limit = 2100;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic CLK_GATE = 1'b0;
    logic IRQ_FLAGS_RD = 1'b0;
    logic load_restart = 1'b0;
    logic upd_sel = 1'b0;
    fcpwm_gen_s GEN_CFG = '0;
    fcpwm_mode_s [FCPWM_NCH-1:0] MODE_CFG = '0;
    logic [15:0] WR_DATA = '0;
    logic [3:0] MODE_WR = '0, PERIOD_WR = '0, DUTY_WR = '0, UPDATE_WR = '0;
    logic [3:0] ENABLE_WR = '0, DISABLE_WR = '0, IRQ_ENABLE_WR = '0, IRQ_DISABLE_WR = '0;
    logic [3:0] CHANNEL_WAVE_OUT, CHANNEL_STATUS, IRQ_MASK, IRQ_FLAGS;
    logic IRQ;
    logic [63:0] COUNTER_VALUE;
    logic [3:0][15:0] high_cnt;
    logic [31:0] seed = 32'h_0ba8_d72b;
    fcpwm_note_s notes[$];
    int mismatches = 0;
    int samples_checked = 0;
    fcpwm_top fcpwm_top_inst (.CLK(CLK), .NRST(NRST), .CLK_GATE(CLK_GATE), .GEN_CFG(GEN_CFG),
        .MODE_CFG(MODE_CFG), .MODE_WR(MODE_WR), .PERIOD_WR(PERIOD_WR), .DUTY_WR(DUTY_WR),
        .UPDATE_WR(UPDATE_WR), .WR_DATA(WR_DATA), .ENABLE_WR(ENABLE_WR),
        .DISABLE_WR(DISABLE_WR), .IRQ_ENABLE_WR(IRQ_ENABLE_WR),
        .IRQ_DISABLE_WR(IRQ_DISABLE_WR), .IRQ_FLAGS_RD(IRQ_FLAGS_RD), .IRQ(IRQ),
        .CHANNEL_WAVE_OUT(CHANNEL_WAVE_OUT), .CHANNEL_STATUS(CHANNEL_STATUS),
        .IRQ_MASK(IRQ_MASK), .IRQ_FLAGS(IRQ_FLAGS), .COUNTER_VALUE(COUNTER_VALUE));
    fcpwm_load fcpwm_load_inst (.clk(CLK), .restart(load_restart), .wave(CHANNEL_WAVE_OUT),
        .high_cnt(high_cnt));
    // ========================================
    // Clock, helpers and the comparing process.
    always #25 CLK = ~CLK;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Inputs move 2 ns after the edge so the design never races the bench.
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask : cyc
    task automatic note(input string name, input logic [15:0] exp, input logic [15:0] got);
        notes.push_back('{name, exp, got});
    endtask : note
    task automatic pulse(ref logic [3:0] s, input logic [3:0] v);
        s = v;
        cyc(1);
        s = '0;
    endtask : pulse
    initial begin : monitor
        fcpwm_note_s n;
        forever begin
            wait (notes.size() != 0);
            n = notes.pop_front();
            samples_checked++;
            if (n.exp !== n.got) begin
                mismatches++;
                $display("wrong value %s expected %0h seen %0h", n.name, n.exp, n.got);
            end
        end
    end
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    // All four channels get one setting; mode, period and duty are set while disabled.
    task automatic setup(input logic pol, input logic alg, input logic [3:0] sel,
        input logic [15:0] p, input logic [15:0] d);
        pulse(DISABLE_WR, 4'h_F);
        for (int c = 0; c < FCPWM_NCH; c++) MODE_CFG[c] = '{sel, alg, pol, upd_sel};
        MODE_WR = 4'h_F;
        WR_DATA = p;
        pulse(PERIOD_WR, 4'h_F);
        MODE_WR = '0;
        WR_DATA = d;
        pulse(DUTY_WR, 4'h_F);
        cyc(1);
        note("wave idle", 16'({4{pol}}), 16'(CHANNEL_WAVE_OUT));
        pulse(ENABLE_WR, 4'h_F);
        note("status", 16'h_000F, 16'(CHANNEL_STATUS));
    endtask : setup
    task automatic wave_case(input logic pol, input logic alg, input logic [15:0] p,
        input logic [15:0] d);
        int w;
        int opp;
        setup(pol, alg, 4'h_0, p, d);
        WR_DATA = p + 16'h_0003;
        pulse(PERIOD_WR, 4'h_F);
        for (int i = 0; i < 100 && COUNTER_VALUE[15:0] !== p; i++) cyc(1);
        cyc(1);
        w = alg ? p : p + 1;
        opp = alg ? p - d : (d == p ? 0 : p + 1 - d);
        for (int k = 0; k < w; k++) begin
            load_restart = (k == 0);
            for (int c = 0; c < 4; c++) note("counter", 16'(alg ? p - 1 - k : k), COUNTER_VALUE[c*16+:16]);
            cyc(1);
        end
        load_restart = 1'b0;
        for (int c = 0; c < 4; c++) note("high cycles", 16'(pol ? w - opp : opp), high_cnt[c]);
    endtask : wave_case
    // Update value written while running must only land at the next period end.
    task automatic upd_case(input logic tgt, input logic [15:0] v, input int w, input int hi);
        upd_sel = tgt;
        setup(1'b0, 1'b0, 4'h_0, 16'h_0004, 16'h_0001);
        upd_sel = 1'b0;
        WR_DATA = v;
        pulse(UPDATE_WR, 4'h_F);
        for (int i = 0; i < 100 && COUNTER_VALUE[15:0] !== 16'h_0004; i++) cyc(1);
        cyc(1);
        for (int k = 0; k < w; k++) begin
            load_restart = (k == 0);
            note("update counter", 16'(k), COUNTER_VALUE[15:0]);
            cyc(1);
        end
        load_restart = 1'b0;
        note("update high", 16'(hi), high_cnt[0]);
    endtask : upd_case
    // Cycles between two counter steps; zero means the selected clock is stopped.
    task automatic gap(input logic [3:0] sel, input int exp);
        int n;
        logic [15:0] v;
        setup(1'b0, 1'b0, sel, 16'h_FFFF, 16'h_0000);
        for (int j = 0; j < 2; j++) begin
            v = COUNTER_VALUE[15:0];
            for (n = 0; n < gap_limit && COUNTER_VALUE[15:0] === v; n++) cyc(1);
        end
        note("tick gap", 16'(exp), 16'(n == gap_limit ? 0 : n));
    endtask : gap
    // ========================================
    // Main sequence.
    initial begin : main
        logic [15:0] p;
        logic [15:0] d;
        cyc(3);
        NRST = 1'b1;
        note("status", 16'h_0000, 16'(CHANNEL_STATUS));
        note("mask", 16'h_0000, 16'(IRQ_MASK));
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            p = 16'(3 + seed[2:0]);
            d = (k < 4) ? 16'(1 + seed[15:8] % (p - 1)) : (k < 6) ? p : 16'h_0000;
            wave_case(k[0], k[1], p, d);
        end
        $display("test waveform done");
        upd_case(1'b0, 16'h_0003, 5, 2);
        upd_case(1'b1, 16'h_0006, 7, 6);
        $display("test update done");
        pulse(IRQ_ENABLE_WR, 4'h_1);
        note("mask", 16'h_0001, 16'(IRQ_MASK));
        setup(1'b0, 1'b0, 4'h_0, 16'h_0004, 16'h_0002);
        cyc(12);
        pulse(DISABLE_WR, 4'h_F);
        note("status", 16'h_0000, 16'(CHANNEL_STATUS));
        note("irq", 16'h_0001, 16'(IRQ));
        note("flags", 16'h_000F, 16'(IRQ_FLAGS));
        IRQ_FLAGS_RD = 1'b1;
        cyc(1);
        IRQ_FLAGS_RD = 1'b0;
        note("flags", 16'h_0000, 16'(IRQ_FLAGS));
        note("irq", 16'h_0000, 16'(IRQ));
        pulse(IRQ_DISABLE_WR, 4'h_1);
        note("mask", 16'h_0000, 16'(IRQ_MASK));
        $display("test interrupt done");
        for (int i = 0; i < FCPWM_NPRE; i++) gap(4'(i), 1 << i);
        gap(FCPWM_SEL_DIVIDER_A_FACTOR, 0);
        GEN_CFG = '{4'h_0, 8'h_FF, 4'h_1, 8'h_03};
        gap(FCPWM_SEL_DIVIDER_A_FACTOR, 6);
        gap(FCPWM_SEL_DIVIDER_B_FACTOR, 255);
        GEN_CFG = '{4'h_0, 8'h_00, 4'h_2, 8'h_01};
        gap(FCPWM_SEL_DIVIDER_A_FACTOR, 4);
        gap(FCPWM_SEL_DIVIDER_B_FACTOR, 0);
        CLK_GATE = 1'b1;
        gap(4'h_1, 0);
        gap(4'h_0, 1);
        CLK_GATE = 1'b0;
        $display("test clock done");
        cyc(2);
        results();
    end
    // A hang past twice the expected run counts as a mismatch.
    initial begin : watchdog
        #(40000 * 50);
        mismatches++;
        $display("watchdog expired");
        results();
    end
endmodule : fcpwm_top_tb
`default_nettype wire
